// >>> nv_pkg.sv
package nv_pkg;
	localparam int ADDR_W = 8;
	localparam int DEPTH = 256;
	localparam logic [11:0] OFF_ADDR = 12'h000;
	localparam logic [11:0] OFF_DATA = 12'h004;
	localparam logic [11:0] OFF_CTRL = 12'h008;
	localparam logic [11:0] OFF_STAT = 12'h00c;
	localparam logic [11:0] OFF_MASK = 12'h010;
	localparam logic [11:0] OFF_TIME = 12'h014;
	localparam int CTRL_RE = 0;
	localparam int CTRL_PE = 1;
	localparam int CTRL_MWE = 2;
	localparam int CTRL_PM_LO = 4;
	localparam int CTRL_PM_HI = 5;
	localparam logic [1:0] PM_ATOMIC = 2'h0;
	localparam logic [1:0] PM_ERASE = 2'h1;
	localparam logic [1:0] PM_WRITE = 2'h2;
	localparam int ST_DONE = 0;
	localparam int ST_REFUSED = 1;
	localparam logic [2:0] MWE_WINDOW = 3'h4;
	localparam logic [2:0] READ_STALL = 3'h4;
	localparam logic [2:0] PROG_STALL = 3'h2;
	localparam int CLK_PERIOD_NS = 100;
	localparam int ERASE_TIME_NS = 1800000;
	localparam int WRITE_TIME_NS = 1800000;
	localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] OSC_CAL_RESET = 8'h80;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage

// >>> nv_mem.sv
module nv_mem
	import nv_pkg::*;
(
	input wire logic pclk,
	input wire logic we,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:DEPTH-1];
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// >>> eeprom_byte_access_ctrl.sv
// Notes on behaviour
// - A separate byte store of 256 bytes is read and written one byte at a time.
// - Address, data and control registers sit in the register space reached by the CPU bus.
// - Starting a read stalls the CPU for four clock cycles.
// - Starting a programming operation stalls the CPU for two clock cycles.
// - Program enable must follow master write enable within four cycles, else nothing starts.
// - Mode zero erases and writes the addressed byte in one operation.
// - Mode 0b01 erases the addressed byte only.
// - Mode 0b10 writes the data byte without erasing first.
// - Program enable stays set for the whole operation and hardware clears it at the end.
// - While programming, any other read or programming start is refused.
// - Storage timing counts oscillator ticks derived from the CPU clock and the calibration value, not every clock cycle.
// - After busy clears, software loads the address and sets read enable to get the byte.
module eeprom_byte_access_ctrl
	import nv_pkg::*;
#(
	parameter int ERASE_CNT = ERASE_CYCLES,
	parameter int WRITE_CNT = WRITE_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic cpu_stall
);
	typedef enum {IDLE, READ_WAIT, ERASING, WRITING} state_t;

	state_t state_reg, state_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [7:0] data_reg, data_next;
	logic [1:0] mode_reg, mode_next;
	logic mwe_reg, mwe_next;
	logic pe_reg, pe_next;
	logic [2:0] mwe_cnt_reg, mwe_cnt_next;
	logic [2:0] stall_cnt_reg, stall_cnt_next;
	logic [21:0] prog_cnt_reg, prog_cnt_next;
	logic [7:0] osc_cal_reg, osc_cal_next;
	logic [1:0] stat_reg, stat_next;
	logic [1:0] mask_reg, mask_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic irq_reg, irq_next;
	logic stall_reg, stall_next;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic [21:0] osc_step;
	logic [21:0] osc_acc_reg, osc_acc_next;
	logic tick;

	nv_mem mem_i (
		.pclk(pclk),
		.we(mem_we),
		.addr(addr_reg),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	// oscillator tick from calibration value
	always_comb begin
		osc_step = {14'h0000, osc_cal_reg} + 22'h000001;
		{tick, osc_acc_next} = {1'b0, osc_acc_reg} + {1'b0, osc_step} + 23'h000000;
		if (osc_acc_reg + osc_step >= 22'h000100) begin
			tick = 1'b1;
			osc_acc_next = osc_acc_reg + osc_step - 22'h000100;
		end else begin
			tick = 1'b0;
			osc_acc_next = osc_acc_reg + osc_step;
		end
	end

	logic wr_access;
	logic rd_access;
	logic busy;
	assign wr_access = psel && penable && pwrite && !pready_reg;
	assign rd_access = psel && penable && !pwrite && !pready_reg;
	assign busy = (state_reg == ERASING) || (state_reg == WRITING);

	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		mode_next = mode_reg;
		mwe_next = mwe_reg;
		pe_next = pe_reg;
		mwe_cnt_next = mwe_cnt_reg;
		stall_cnt_next = stall_cnt_reg;
		prog_cnt_next = prog_cnt_reg;
		osc_cal_next = osc_cal_reg;
		stat_next = stat_reg;
		mask_next = mask_reg;
		prdata_next = prdata_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		mem_we = 1'b0;
		mem_wdata = data_reg;
		if (stall_cnt_reg != 3'h0) begin
			stall_cnt_next = stall_cnt_reg - 3'h1;
		end
		if (mwe_reg) begin
			if (mwe_cnt_reg == 3'h1) begin
				mwe_next = 1'b0;
			end
			mwe_cnt_next = mwe_cnt_reg - 3'h1;
		end
		case (state_reg)
			READ_WAIT: begin
				data_next = mem_rdata;
				state_next = IDLE;
			end
			ERASING: begin
				if (tick) begin
					prog_cnt_next = prog_cnt_reg - 22'h000001;
				end
				if (prog_cnt_reg == 22'h000000) begin
					mem_we = 1'b1;
					mem_wdata = ERASED_BYTE;
					if (mode_reg == PM_ATOMIC) begin
						state_next = WRITING;
						prog_cnt_next = 22'(WRITE_CNT);
					end else begin
						state_next = IDLE;
						pe_next = 1'b0;
						stat_next[ST_DONE] = 1'b1;
					end
				end
			end
			WRITING: begin
				if (tick) begin
					prog_cnt_next = prog_cnt_reg - 22'h000001;
				end
				if (prog_cnt_reg == 22'h000000) begin
					mem_we = 1'b1;
					mem_wdata = (mode_reg == PM_WRITE) ? (data_reg & mem_rdata) : data_reg;
					state_next = IDLE;
					pe_next = 1'b0;
					stat_next[ST_DONE] = 1'b1;
				end
			end
			default: begin
			end
		endcase
		if (psel && penable && !pready_reg) begin
			pready_next = 1'b1;
		end
		if (wr_access) begin
			if (paddr == OFF_ADDR) begin
				if (!busy) begin
					addr_next = pwdata[ADDR_W-1:0];
				end
			end else if (paddr == OFF_DATA) begin
				if (!busy) begin
					data_next = pwdata[7:0];
				end
			end else if (paddr == OFF_CTRL) begin
				if (busy) begin
					if (pwdata[CTRL_RE] || pwdata[CTRL_PE]) begin
						stat_next[ST_REFUSED] = 1'b1;
					end
				end else begin
					mode_next = {pwdata[CTRL_PM_HI], pwdata[CTRL_PM_LO]};
					if (pwdata[CTRL_MWE] && !mwe_reg) begin
						mwe_next = 1'b1;
						mwe_cnt_next = MWE_WINDOW;
					end
					if (pwdata[CTRL_PE] && mwe_reg) begin
						if ({pwdata[CTRL_PM_HI], pwdata[CTRL_PM_LO]} == PM_WRITE) begin
							state_next = WRITING;
							prog_cnt_next = 22'(WRITE_CNT);
							pe_next = 1'b1;
							stall_cnt_next = PROG_STALL;
						end else if ({pwdata[CTRL_PM_HI], pwdata[CTRL_PM_LO]} != 2'h3) begin
							state_next = ERASING;
							prog_cnt_next = 22'(ERASE_CNT);
							pe_next = 1'b1;
							stall_cnt_next = PROG_STALL;
						end
						mwe_next = 1'b0;
					end else if (pwdata[CTRL_RE]) begin
						state_next = READ_WAIT;
						stall_cnt_next = READ_STALL;
					end
				end
			end else if (paddr == OFF_STAT) begin
				stat_next = stat_next & ~(pwdata[1:0] & ~stat_reg_set(state_reg, prog_cnt_reg, mode_reg));
			end else if (paddr == OFF_MASK) begin
				mask_next = pwdata[1:0];
			end else if (paddr == OFF_TIME) begin
				osc_cal_next = pwdata[7:0];
			end else begin
				pslverr_next = 1'b1;
			end
		end
		if (rd_access) begin
			if (paddr == OFF_ADDR) begin
				prdata_next = {24'h000000, addr_reg};
			end else if (paddr == OFF_DATA) begin
				prdata_next = {24'h000000, data_reg};
			end else if (paddr == OFF_CTRL) begin
				prdata_next = {26'h0000000, mode_reg, 1'b0, mwe_reg, pe_reg, 1'b0};
			end else if (paddr == OFF_STAT) begin
				prdata_next = {30'h00000000, stat_reg};
			end else if (paddr == OFF_MASK) begin
				prdata_next = {30'h00000000, mask_reg};
			end else if (paddr == OFF_TIME) begin
				prdata_next = {24'h000000, osc_cal_reg};
			end else begin
				prdata_next = 32'h00000000;
				pslverr_next = 1'b1;
			end
		end
		irq_next = |(stat_next & mask_next);
		stall_next = (stall_cnt_next != 3'h0);
	end

	// done event this cycle, so a clear cannot drop it
	function automatic logic [1:0] stat_reg_set(input state_t st, input logic [21:0] cnt, input logic [1:0] md);
		logic [1:0] s;
		s = 2'h0;
		if (cnt == 22'h000000) begin
			if (st == WRITING || (st == ERASING && md != PM_ATOMIC)) begin
				s[ST_DONE] = 1'b1;
			end
		end
		return s;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= IDLE;
			addr_reg <= 8'h00;
			data_reg <= 8'h00;
			mode_reg <= 2'h0;
			mwe_reg <= 1'b0;
			pe_reg <= 1'b0;
			mwe_cnt_reg <= 3'h0;
			stall_cnt_reg <= 3'h0;
			prog_cnt_reg <= 22'h000000;
			osc_cal_reg <= OSC_CAL_RESET;
			osc_acc_reg <= 22'h000000;
			stat_reg <= 2'h0;
			mask_reg <= 2'h0;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
			stall_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			mode_reg <= mode_next;
			mwe_reg <= mwe_next;
			pe_reg <= pe_next;
			mwe_cnt_reg <= mwe_cnt_next;
			stall_cnt_reg <= stall_cnt_next;
			prog_cnt_reg <= prog_cnt_next;
			osc_cal_reg <= osc_cal_next;
			osc_acc_reg <= osc_acc_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg <= irq_next;
			stall_reg <= stall_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign cpu_stall = stall_reg;

	mwe_self_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(mwe_reg) |-> ##[1:4] !mwe_reg)
		else $error("master write enable not cleared in window");
	read_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == IDLE && state_next == READ_WAIT) |=> cpu_stall [*3] ##1 cpu_stall ##1 !cpu_stall)
		else $error("read stall not four cycles");
	prog_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!busy && pe_next && !pe_reg) |=> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
		else $error("program stall not two cycles");
	pe_needs_mwe_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(pe_reg) |-> $past(mwe_reg))
		else $error("programming began without master enable");
	pe_held_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
		busy |-> pe_reg)
		else $error("program enable dropped while busy");
	pe_cleared_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(busy) |-> !pe_reg)
		else $error("program enable left set after operation");
	no_start_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
		busy && $past(busy) |-> $stable(addr_reg) && state_reg != READ_WAIT)
		else $error("access started during programming");
	reserved_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_access && paddr == OFF_CTRL && !busy && pwdata[CTRL_PM_HI] && pwdata[CTRL_PM_LO]) |=> !busy)
		else $error("reserved mode started an operation");
	read_data_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == READ_WAIT |=> data_reg == $past(mem_rdata))
		else $error("read byte not placed in data register");
endmodule

// >>> cpu_model.sv
module cpu_model
	import nv_pkg::*;
(
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// one apb transfer, held until pready is sampled high or 20 cycles pass
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic hung);
		int n;
		hung = 1'b1;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				hung = 1'b0;
				break;
			end
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released bus shows no stale value
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// >>> eeprom_byte_access_ctrl_tb_top.sv
module eeprom_byte_access_ctrl_tb_top
	import nv_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq, cpu_stall;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int error_cnt = 0;
	int tests_run = 0;
	int stall_run = 0;
	int stall_last = 0;
	eeprom_byte_access_ctrl #(.ERASE_CNT(4), .WRITE_CNT(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .cpu_stall(cpu_stall));
	cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		forever #50 pclk = ~pclk;
	end
	// length of the last stall pulse
	always @(posedge pclk) begin
		if (cpu_stall === 1'b1) begin
			stall_run <= stall_run + 1;
		end else if (stall_run != 0) begin
			stall_last <= stall_run;
			stall_run <= 0;
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		logic h;
		cpu.xfer(w, a, d, r, e, h);
		if (h !== 1'b0) begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		acc(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		acc(1'b0, a, 32'h0, r, e);
	endtask
	task automatic wait_idle;
		logic [31:0] r;
		int n;
		for (n = 0; n < 200; n++) begin
			rd(OFF_CTRL, r);
			if (r[CTRL_PE] === 1'b0) return;
		end
		error_cnt++;
		report_and_stop();
	endtask
	task automatic prog(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
		wr(OFF_ADDR, {24'h0, a});
		wr(OFF_DATA, {24'h0, d});
		wr(OFF_CTRL, (32'(m) << CTRL_PM_LO) | (32'h1 << CTRL_MWE));
		wr(OFF_CTRL, (32'(m) << CTRL_PM_LO) | (32'h1 << CTRL_MWE) | (32'h1 << CTRL_PE));
	endtask
	task automatic nv_read(input logic [7:0] a, output logic [31:0] r);
		wr(OFF_ADDR, {24'h0, a});
		wr(OFF_CTRL, 32'h1 << CTRL_RE);
		rd(OFF_DATA, r);
	endtask
	initial begin
		logic e;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_TIME, q);
		check("osc_cal reset", q, {24'h0, OSC_CAL_RESET});
		rd(OFF_STAT, q);
		check("status reset", q, 32'h0);
		acc(1'b0, 12'h100, 32'h0, q, e);
		check("unmapped err", {31'h0, e}, 32'h1);
		check("unmapped data", q, 32'h0);
		acc(1'b1, 12'h100, 32'h0, q, e);
		check("unmapped wr err", {31'h0, e}, 32'h1);
		wr(OFF_TIME, 32'h3f);
		rd(OFF_TIME, q);
		check("osc_cal", q, 32'h3f);
		wr(OFF_MASK, 32'h3);
		prog(PM_ATOMIC, 8'hff, 8'h3c);
		rd(OFF_CTRL, q);
		check("busy", {31'h0, q[CTRL_PE]}, 32'h1);
		check("prog stall", stall_last, 32'(PROG_STALL));
		wr(OFF_CTRL, 32'h1 << CTRL_RE);
		wr(OFF_ADDR, 32'h77);
		wait_idle();
		rd(OFF_STAT, q);
		check("status", q, 32'h3);
		check("irq set", {31'h0, irq}, 32'h1);
		wr(OFF_STAT, 32'h3);
		check("irq clear", {31'h0, irq}, 32'h0);
		rd(OFF_ADDR, q);
		check("addr kept", q, 32'hff);
		nv_read(8'hff, q);
		check("atomic", q, 32'h3c);
		// let the pulse counter settle before looking
		@(negedge pclk);
		check("read stall", stall_last, 32'(READ_STALL));
		wr(OFF_MASK, 32'h0);
		prog(PM_ERASE, 8'hff, 8'h00);
		wait_idle();
		check("irq masked", {31'h0, irq}, 32'h0);
		rd(OFF_MASK, q);
		check("mask", q, 32'h0);
		wr(OFF_MASK, 32'h3);
		check("irq unmasked", {31'h0, irq}, 32'h1);
		wr(OFF_STAT, 32'h3);
		nv_read(8'hff, q);
		check("erase", q, {24'h0, ERASED_BYTE});
		prog(PM_WRITE, 8'hff, 8'h5a);
		wait_idle();
		nv_read(8'hff, q);
		check("write only", q, 32'h5a);
		prog(2'h3, 8'hff, 8'h00);
		rd(OFF_CTRL, q);
		check("reserved mode", {31'h0, q[CTRL_PE]}, 32'h0);
		wr(OFF_CTRL, 32'h1 << CTRL_PE);
		rd(OFF_CTRL, q);
		check("no master", {31'h0, q[CTRL_PE]}, 32'h0);
		wr(OFF_CTRL, 32'h1 << CTRL_MWE);
		repeat (5) @(posedge pclk);
		wr(OFF_CTRL, (32'h1 << CTRL_MWE) | (32'h1 << CTRL_PE));
		rd(OFF_CTRL, q);
		check("late enable", {31'h0, q[CTRL_PE]}, 32'h0);
		nv_read(8'hff, q);
		check("unchanged", q, 32'h5a);
		report_and_stop();
	end
endmodule
